/* File: shared/fkp_pkg.sv */
// Constants, opcodes and register map of the flag and key port block.
// Assumes one 100 MHz clock shared by the core, the bus and this block.
package fkp_pkg;

    // ============================================================
    // Register map
    localparam logic [7:0] FKP_OFS_SCAN   = 8'h00;
    localparam logic [7:0] FKP_OFS_KEYIN  = 8'h04;
    localparam logic [7:0] FKP_OFS_TMRCTL = 8'h08;
    localparam logic [7:0] FKP_OFS_MODE   = 8'h0C;
    localparam logic [7:0] FKP_OFS_FLAGS  = 8'h10;
    localparam logic [7:0] FKP_ADDR_MASK  = 8'hFC;

    // ============================================================
    // Reset values and writable masks
    localparam logic [7:0] FKP_RST_SCAN   = 8'hFF;
    localparam logic [7:0] FKP_RST_TMRCTL = 8'h03;
    localparam logic [7:0] FKP_RST_MODE   = 8'h26;
    localparam logic [7:0] FKP_WMASK_TMR  = 8'h3F;
    localparam logic [7:0] FKP_WMASK_MODE = 8'h37;

    // ============================================================
    // Mode register fields
    localparam int FKP_MODE_S0_IN   = 0;
    localparam int FKP_MODE_SCANOUT = 1;
    localparam int FKP_MODE_SPECIAL_IO_INDICATOR  = 2;
    localparam int FKP_MODE_S_PD    = 4;
    localparam int FKP_MODE_KI_PD   = 5;

    // ============================================================
    // Flags register fields
    localparam int FKP_FLG_STATUS  = 0;
    localparam int FKP_FLG_CARRY   = 1;
    localparam int FKP_FLG_STANDBY = 2;

    // ============================================================
    // Test operand encodings and accumulator constants
    localparam int         FKP_TST_SPECIAL = 3;
    localparam logic [2:0] FKP_TST_KI_A    = 3'h0;
    localparam logic [2:0] FKP_TST_KI_B    = 3'h3;
    localparam logic [2:0] FKP_TST_KI_C    = 3'h6;
    localparam logic [2:0] FKP_TST_TIMER   = 3'h5;
    localparam int         FKP_ACC_MSB     = 3;
    localparam logic [3:0] FKP_ACC_FULL    = 4'hF;
    localparam logic [1:0] FKP_LOW_ONES    = 2'h3;

    // ============================================================
    // Bus answers
    localparam logic [1:0] FKP_RESP_OKAY   = 2'h0;
    localparam logic [1:0] FKP_RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        FKP_OP_NONE, FKP_OP_TEST, FKP_OP_HALT, FKP_OP_AND, FKP_OP_XOR,
        FKP_OP_OR, FKP_OP_RL, FKP_OP_RLZ, FKP_OP_INC, FKP_OP_SET_CARRY_ADD_OP,
        FKP_OP_MOV, FKP_OP_IN
    } fkp_op_t;

    typedef enum logic {
        FKP_RUN_ACTIVE, FKP_RUN_STANDBY
    } fkp_run_t;

endpackage

/* File: testbench/fkp_pins.sv */
// Key matrix and switch pins at the far side of the key port block.
// Assumes the bench says which keys are pressed; undriven lines obey pulls.
`timescale 1ns/10ps
module fkp_pins (
    input  wire logic [3:0] key_press,          // Pressed key inputs
    input  wire logic [7:0] scan_press,         // Scan lines pulled high by keys
    input  wire logic       s0_level,           // Switch on special input zero
    input  wire logic [7:0] scan_out,           // Scan drive value
    input  wire logic [7:0] scan_oe,            // Scan drive enable
    input  wire logic       scan_pd_en,         // Scan pull-down
    input  wire logic       special_io_out,     // Indicator drive value
    input  wire logic       special_io_oe,      // Indicator drive enable
    output logic      [3:0] key_input_pins,     // Key input levels
    output logic      [7:0] scan_in,            // Scan line levels
    output logic            special_input_zero, // Special input zero level
    output logic            special_io_in       // Indicator line level
);
    // ============================================================
    // Wire levels
    always_comb begin
        key_input_pins = key_press;
        special_input_zero = s0_level;
        special_io_in = special_io_oe ? special_io_out : 1'b0;
        // Floating line without pull-down shows the inverse of the last drive
        for (int i = 0; i < 8; i++) begin
            scan_in[i] = scan_oe[i] ? scan_out[i]
                       : (scan_press[i] | (!scan_pd_en & !scan_out[i]));
        end
    end
endmodule

/* File: testbench/tb.sv */
// Bench for the flag and key port block: bus tasks, core strobes, pin model.
// Assumes a 100 MHz core_clk and one-cycle bus answers of the block.
`timescale 1ns/10ps
module tb;
    import fkp_pkg::*;
    logic core_clk = 1'b0, nrst = 1'b0, op_valid = 1'b0, timer_zero = 1'b0;
    logic release_cond = 1'b0, indicator_level = 1'b0, s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    fkp_op_t op_code = FKP_OP_NONE;
    logic [3:0] op_operand = 4'h0, acc_value = 4'h0, key_press = 4'h0, key_input_pins;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, scan_press = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic status_flag, carry_bit, standby, scan_pd_en, special_io_out, special_io_oe;
    logic special_input_zero, special_io_in, s0_level = 1'b0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] scan_out, scan_oe, scan_in;
    int fail_count = 0, comparisons = 0, cycles = 0;
    fkp_top u_dut (.core_clk, .nrst, .op_valid, .op_code, .op_operand, .acc_value, .timer_zero,
        .release_cond, .indicator_level, .status_flag, .carry_bit, .standby, .carrier_ctl(),
        .key_input_pins, .scan_in, .scan_out, .scan_oe, .scan_pd_en, .ki_pd_en(), .s0_pd_en(),
        .special_input_zero, .special_io_in, .special_io_out, .special_io_oe, .s1_pd_en(),
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    fkp_pins u_pins (.key_press, .scan_press, .s0_level, .scan_out, .scan_oe, .scan_pd_en,
        .special_io_out, .special_io_oe, .key_input_pins, .scan_in, .special_input_zero,
        .special_io_in);
    // ============================================================
    // Clock, watchdog, verdict
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    // ============================================================
    // Bus and core tasks
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic aw_p = 1'b1, w_p = 1'b1;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        // Ready is read mid-cycle, where it is settled for the coming edge
        while (aw_p || w_p) begin
            @(negedge core_clk);
            aw_p = aw_p && !s_axi_awready;
            w_p = w_p && !s_axi_wready;
            @(posedge core_clk);
            {s_axi_awvalid, s_axi_wvalid} <= {aw_p, w_p};
        end
        do @(negedge core_clk); while (s_axi_bvalid !== 1'b1);
        check("bresp", s_axi_bresp, FKP_RESP_OKAY);
        @(posedge core_clk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] r);
        @(posedge core_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(negedge core_clk); while (s_axi_arready !== 1'b1);
        @(posedge core_clk);
        s_axi_arvalid <= 1'b0;
        do @(negedge core_clk); while (s_axi_rvalid !== 1'b1);
        check(n, s_axi_rdata, e);
        check(n, s_axi_rresp, r);
        @(posedge core_clk);
        s_axi_rready <= 1'b0;
    endtask
    task automatic op(input fkp_op_t c, input logic [3:0] o, input logic [3:0] a);
        @(posedge core_clk);
        op_valid <= 1'b1;
        op_code <= c;
        {op_operand, acc_value} <= {o, a};
        @(posedge core_clk);
        op_valid <= 1'b0;
        @(negedge core_clk);
    endtask
    // ============================================================
    // Tests
    initial begin
        fkp_op_t cc[16] = '{FKP_OP_AND, FKP_OP_XOR, FKP_OP_XOR, FKP_OP_OR, FKP_OP_RL, FKP_OP_RLZ,
            FKP_OP_RLZ, FKP_OP_INC, FKP_OP_INC, FKP_OP_MOV, FKP_OP_SET_CARRY_ADD_OP, FKP_OP_SET_CARRY_ADD_OP, FKP_OP_INC,
            FKP_OP_IN, FKP_OP_INC, FKP_OP_AND};
        logic [3:0] ca[16] = '{4'h8, 4'h7, 4'h9, 4'hF, 4'h8, 4'h7, 4'hF, 4'hE, 4'hF, 4'hF, 4'hF,
            4'hE, 4'hF, 4'hF, 4'hF, 4'hF};
        logic [15:0] ce = 16'h5555;
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        rd("latch", FKP_OFS_SCAN, 32'hFF, FKP_RESP_OKAY);
        rd("tmrctl", FKP_OFS_TMRCTL, 32'h03, FKP_RESP_OKAY);
        rd("mode", FKP_OFS_MODE, 32'h26, FKP_RESP_OKAY);
        rd("keyin", FKP_OFS_KEYIN, 32'h07, FKP_RESP_OKAY);
        rd("unmapped", 8'h20, 32'h0, FKP_RESP_SLVERR);
        wr(FKP_OFS_SCAN, 8'h5A);
        rd("latch", FKP_OFS_SCAN, 32'h5A, FKP_RESP_OKAY);
        check("scan pd", {scan_pd_en, scan_oe}, 9'h0FF);
        wr(FKP_OFS_MODE, 8'h24);
        scan_press <= 8'h81;
        wr(FKP_OFS_SCAN, 8'hC3);
        rd("pins", FKP_OFS_SCAN, 32'h81, FKP_RESP_OKAY);
        check("scan pd", {scan_pd_en, scan_oe}, 9'h100);
        wr(FKP_OFS_MODE, 8'h26);
        rd("latch", FKP_OFS_SCAN, 32'hC3, FKP_RESP_OKAY);
        for (int p = 0; p < 2; p++) begin
            @(posedge core_clk);
            key_press <= p ? 4'h0 : 4'h2;
            {timer_zero, indicator_level} <= {2{p[0]}};
            repeat (3) @(posedge core_clk);
            for (int i = 0; i < 16; i++) begin
                op(FKP_OP_TEST, i[3:0], 4'h0);
                check("test", status_flag, p ? (i % 8 == 5 || i > 7) : (i % 8 inside {0, 3, 6}));
            end
        end
        for (int i = 0; i < 16; i++) begin
            op(cc[i], (i == 15) ? 4'h7 : 4'h8, ca[i]);
            check("carry", carry_bit, ce[i]);
        end
        wr(FKP_OFS_MODE, 8'h23);
        s0_level <= 1'b1;
        repeat (3) @(posedge core_clk);
        op(FKP_OP_TEST, 4'h1, 4'h0);
        op(FKP_OP_TEST, 4'h9, 4'h0);
        check("s0 test", status_flag, 1'b1);
        @(posedge core_clk);
        s0_level <= 1'b0;
        repeat (3) @(posedge core_clk);
        rd("keyin s0", FKP_OFS_KEYIN, 32'h03, FKP_RESP_OKAY);
        op(FKP_OP_TEST, 4'h1, 4'h0);
        op(FKP_OP_HALT, 4'h0, 4'h0);
        op(FKP_OP_TEST, 4'h5, 4'h0);
        check("standby", {standby, status_flag}, 2'h2);
        @(posedge core_clk);
        release_cond <= 1'b1;
        repeat (2) @(negedge core_clk);
        check("release", {standby, status_flag}, 2'h1);
        op(FKP_OP_TEST, 4'h1, 4'h0);
        op(FKP_OP_HALT, 4'h0, 4'h0);
        check("halt pend", {standby, status_flag}, 2'h1);
        @(posedge core_clk);
        release_cond <= 1'b0;
        op(FKP_OP_HALT, 4'h0, 4'h0);
        check("halt flag", {standby, status_flag}, 2'h0);
        print_verdict();
    end
endmodule

/* File: verilog/fkp_sync.sv */
// Two-stage synchroniser for a group of pin levels.
// Assumes each bit is an independent level; no bus coherence is promised.
`timescale 1ns/10ps
module fkp_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk, // System clock
    input  wire logic         nrst,     // Synchronous reset, active low
    input  wire logic [W-1:0] async_in, // Pin levels
    output logic      [W-1:0] sync_out  // Levels after two flops
);

    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } fkp_sync_state_t;

    fkp_sync_state_t st_q;
    fkp_sync_state_t st_d;

    // ============================================================
    // Next state
    always_comb begin
        st_d        = st_q;
        st_d.stage1 = async_in;
        st_d.stage2 = st_q.stage1;
        if (!nrst) begin
            st_d = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        st_q <= st_d;
    end

    assign sync_out = st_q.stage2;

endmodule

/* File: verilog/fkp_top.sv */
// Status and carry flags, port registers and key-scan port with AXI4-Lite access.
// Assumes core opcode strobes and timer status arrive on core_clk; pins are async.
`timescale 1ns/10ps
module fkp_top
    import fkp_pkg::*;
(
    input  wire logic        core_clk,        // System clock, 100 MHz
    input  wire logic        nrst,            // Synchronous reset, active low
    // Core instruction side
    input  wire logic        op_valid,        // One-cycle instruction strobe
    input  wire fkp_op_t     op_code,         // Executed instruction kind
    input  wire logic [3:0]  op_operand,      // Instruction operand
    input  wire logic [3:0]  acc_value,       // Accumulator before the instruction
    input  wire logic        timer_zero,      // Timer down counter is zero
    input  wire logic        release_cond,    // Standby release condition
    input  wire logic        indicator_level, // Level for indicator pin in output mode
    output logic             status_flag,     // Status flag
    output logic             carry_bit,       // Carry flag
    output logic             standby,         // Core held in standby
    output logic [7:0]       carrier_ctl,     // Timer and carrier control bits
    // Pins
    input  wire logic [3:0]  key_input_pins,  // Key inputs
    input  wire logic [7:0]  scan_in,         // Key-scan pin levels
    output logic      [7:0]  scan_out,        // Key-scan drive value
    output logic      [7:0]  scan_oe,         // Key-scan drive enable
    output logic             scan_pd_en,      // Key-scan pull-down enable
    output logic             ki_pd_en,        // Key input pull-down enable
    input  wire logic        special_input_zero,   // Special input pin 0
    output logic             s0_pd_en,        // Special input 0 pull-down
    input  wire logic        special_io_in,   // Indicator pin level
    output logic             special_io_out,  // Indicator pin drive value
    output logic             special_io_oe,   // Indicator pin drive enable
    output logic             s1_pd_en,        // Indicator pin pull-down
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,    // Write address
    input  wire logic        s_axi_awvalid,   // Write address valid
    output logic             s_axi_awready,   // Write address ready
    input  wire logic [31:0] s_axi_wdata,     // Write data
    input  wire logic [3:0]  s_axi_wstrb,     // Write byte strobes
    input  wire logic        s_axi_wvalid,    // Write data valid
    output logic             s_axi_wready,    // Write data ready
    output logic [1:0]       s_axi_bresp,     // Write response
    output logic             s_axi_bvalid,    // Write response valid
    input  wire logic        s_axi_bready,    // Write response ready
    input  wire logic [7:0]  s_axi_araddr,    // Read address
    input  wire logic        s_axi_arvalid,   // Read address valid
    output logic             s_axi_arready,   // Read address ready
    output logic [31:0]      s_axi_rdata,     // Read data
    output logic [1:0]       s_axi_rresp,     // Read response
    output logic             s_axi_rvalid,    // Read data valid
    input  wire logic        s_axi_rready     // Read data ready
);

    typedef struct packed {
        fkp_run_t    run;
        logic        status_flag;
        logic        carry_bit;
        logic [7:0]  scan_latch;
        logic [7:0]  timer_ctl;
        logic [7:0]  mode_ctl;
        logic        aw_done;
        logic [7:0]  aw_addr;
        logic        w_done;
        logic [7:0]  w_byte;
        logic        w_strb0;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } fkp_state_t;

    fkp_state_t st_q;
    fkp_state_t st_d;

    logic [3:0] ki_s;
    logic [7:0] scan_s;
    logic       s0_s;
    logic       s1_s;
    logic       s0_read;
    logic       low_cond;
    logic       spec_cond;
    logic       test_cond;
    logic       active_op;
    logic [7:0] scan_read;
    logic [7:0] keyin_read;
    logic [7:0] flags_read;
    logic [7:0] waddr;
    logic [7:0] raddr;

    // ============================================================
    // Pin synchronisers
    fkp_sync #(
        .W (14)
    ) u_pin_sync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .async_in ({key_input_pins, scan_in, special_input_zero, special_io_in}),
        .sync_out ({ki_s, scan_s, s0_s, s1_s})
    );

    // ============================================================
    // Test condition
    // Off-mode pin floats: it reads as one in the key input view but never satisfies the test
    assign s0_read   = st_q.mode_ctl[FKP_MODE_S0_IN] ? s0_s : 1'b1;
    assign spec_cond = (st_q.mode_ctl[FKP_MODE_S0_IN] & s0_s) | s1_s;

    always_comb begin
        low_cond = 1'b0;
        if (op_operand[2:0] == FKP_TST_KI_A || op_operand[2:0] == FKP_TST_KI_B ||
            op_operand[2:0] == FKP_TST_KI_C) begin
            low_cond = |ki_s;
        end else if (op_operand[2:0] == FKP_TST_TIMER) begin
            low_cond = timer_zero;
        end
    end

    assign test_cond = low_cond | (op_operand[FKP_TST_SPECIAL] & spec_cond);
    assign active_op = op_valid && st_q.run == FKP_RUN_ACTIVE;

    // ============================================================
    // Register read views
    assign scan_read  = st_q.mode_ctl[FKP_MODE_SCANOUT] ? st_q.scan_latch : scan_s;
    assign keyin_read = {ki_s, s1_s, s0_read, FKP_LOW_ONES};
    assign flags_read = {5'h00, st_q.run == FKP_RUN_STANDBY, st_q.carry_bit,
                         st_q.status_flag};
    assign waddr      = st_q.aw_addr & FKP_ADDR_MASK;
    assign raddr      = s_axi_araddr & FKP_ADDR_MASK;

    // ============================================================
    // Next state
    always_comb begin
        st_d = st_q;

        // Flags and standby
        case (st_q.run)
            FKP_RUN_ACTIVE: begin
                if (op_valid) begin
                    case (op_code)
                        FKP_OP_TEST: st_d.status_flag = test_cond;
                        FKP_OP_HALT: begin
                            if (release_cond) begin
                                st_d.status_flag = 1'b1;
                            end else if (st_q.status_flag) begin
                                st_d.status_flag = 1'b0;
                            end else begin
                                st_d.run = FKP_RUN_STANDBY;
                            end
                        end
                        FKP_OP_AND, FKP_OP_XOR: begin
                            st_d.carry_bit = acc_value[FKP_ACC_MSB] &
                                             op_operand[FKP_ACC_MSB];
                        end
                        FKP_OP_RL, FKP_OP_RLZ: begin
                            st_d.carry_bit = acc_value[FKP_ACC_MSB];
                        end
                        FKP_OP_INC, FKP_OP_SET_CARRY_ADD_OP: begin
                            st_d.carry_bit = (acc_value == FKP_ACC_FULL);
                        end
                        FKP_OP_OR: st_d.carry_bit = 1'b0;
                        FKP_OP_MOV, FKP_OP_IN: st_d.carry_bit = 1'b0;
                        default: ;
                    endcase
                end
            end
            FKP_RUN_STANDBY: begin
                // Core is stalled here, so strobes are ignored
                if (release_cond) begin
                    st_d.run         = FKP_RUN_ACTIVE;
                    st_d.status_flag = 1'b1;
                end
            end
            default: st_d.run = FKP_RUN_ACTIVE;
        endcase

        // Write address and data, taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_d.aw_done = 1'b1;
            st_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_d.w_done  = 1'b1;
            st_d.w_byte  = s_axi_wdata[7:0];
            st_d.w_strb0 = s_axi_wstrb[0];
        end
        if (st_q.aw_done && st_q.w_done && !st_q.bvalid) begin
            st_d.aw_done = 1'b0;
            st_d.w_done  = 1'b0;
            st_d.bvalid  = 1'b1;
            st_d.bresp   = FKP_RESP_OKAY;
            if (waddr == FKP_OFS_SCAN) begin
                if (st_q.w_strb0) begin
                    st_d.scan_latch = st_q.w_byte;
                end
            end else if (waddr == FKP_OFS_TMRCTL) begin
                if (st_q.w_strb0) begin
                    st_d.timer_ctl = st_q.w_byte & FKP_WMASK_TMR;
                end
            end else if (waddr == FKP_OFS_MODE) begin
                if (st_q.w_strb0) begin
                    st_d.mode_ctl = st_q.w_byte & FKP_WMASK_MODE;
                end
            end else if (waddr == FKP_OFS_KEYIN || waddr == FKP_OFS_FLAGS) begin
                // Read-only: write ignored
                st_d.bresp = FKP_RESP_OKAY;
            end else begin
                st_d.bresp = FKP_RESP_SLVERR;
            end
        end else if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end

        // Read
        if (s_axi_arvalid && s_axi_arready) begin
            st_d.rvalid = 1'b1;
            st_d.rresp  = FKP_RESP_OKAY;
            st_d.rdata  = '0;
            if (raddr == FKP_OFS_SCAN) begin
                st_d.rdata[7:0] = scan_read;
            end else if (raddr == FKP_OFS_KEYIN) begin
                st_d.rdata[7:0] = keyin_read;
            end else if (raddr == FKP_OFS_TMRCTL) begin
                st_d.rdata[7:0] = st_q.timer_ctl;
            end else if (raddr == FKP_OFS_MODE) begin
                st_d.rdata[7:0] = st_q.mode_ctl;
            end else if (raddr == FKP_OFS_FLAGS) begin
                st_d.rdata[7:0] = flags_read;
            end else begin
                st_d.rresp = FKP_RESP_SLVERR;
            end
        end else if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end

        if (!nrst) begin
            st_d            = '0;
            st_d.run        = FKP_RUN_ACTIVE;
            st_d.scan_latch = FKP_RST_SCAN;
            st_d.timer_ctl  = FKP_RST_TMRCTL;
            st_d.mode_ctl   = FKP_RST_MODE;
        end
    end

    always_ff @(posedge core_clk) begin
        st_q <= st_d;
    end

    // ============================================================
    // Outputs
    assign status_flag    = st_q.status_flag;
    assign carry_bit      = st_q.carry_bit;
    assign standby        = (st_q.run == FKP_RUN_STANDBY);
    assign carrier_ctl    = st_q.timer_ctl;
    assign scan_out       = st_q.scan_latch;
    assign scan_oe        = {8{st_q.mode_ctl[FKP_MODE_SCANOUT]}};
    assign scan_pd_en     = ~st_q.mode_ctl[FKP_MODE_SCANOUT];
    assign ki_pd_en       = st_q.mode_ctl[FKP_MODE_KI_PD];
    assign s0_pd_en       = st_q.mode_ctl[FKP_MODE_S_PD] & st_q.mode_ctl[FKP_MODE_S0_IN];
    assign s1_pd_en       = st_q.mode_ctl[FKP_MODE_S_PD] & ~st_q.mode_ctl[FKP_MODE_SPECIAL_IO_INDICATOR];
    assign special_io_oe  = st_q.mode_ctl[FKP_MODE_SPECIAL_IO_INDICATOR];
    assign special_io_out = indicator_level;

    // Writes stall until the previous answer is taken
    assign s_axi_awready  = ~st_q.aw_done & ~st_q.bvalid;
    assign s_axi_wready   = ~st_q.w_done & ~st_q.bvalid;
    assign s_axi_bvalid   = st_q.bvalid;
    assign s_axi_bresp    = st_q.bresp;
    assign s_axi_arready  = ~st_q.rvalid;
    assign s_axi_rvalid   = st_q.rvalid;
    assign s_axi_rdata    = st_q.rdata;
    assign s_axi_rresp    = st_q.rresp;

    // ============================================================
    // Assertions
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    test_sets_flag_a: assert property (
        active_op && op_code == FKP_OP_TEST && test_cond |=> status_flag)
        else $error("test with true condition did not set status flag");

    test_clears_flag_a: assert property (
        active_op && op_code == FKP_OP_TEST && !test_cond |=> !status_flag)
        else $error("test with false condition did not clear status flag");

    release_sets_flag_a: assert property (
        standby && release_cond |=> status_flag && !standby)
        else $error("standby release did not set flag and resume");

    halt_release_a: assert property (
        active_op && op_code == FKP_OP_HALT && release_cond |=> status_flag && !standby)
        else $error("halt with release pending entered standby or left flag clear");

    halt_flag_clear_a: assert property (
        active_op && op_code == FKP_OP_HALT && !release_cond && status_flag
        |=> !status_flag && !standby)
        else $error("halt with flag set did not clear flag and stay active");

    halt_standby_a: assert property (
        active_op && op_code == FKP_OP_HALT && !release_cond && !status_flag
        |=> standby ##0 (standby && !release_cond)[*1] |=> standby)
        else $error("halt with flag clear did not hold standby");

    key_cond_a: assert property (
        op_operand[2:0] == FKP_TST_KI_B && !op_operand[FKP_TST_SPECIAL]
        |-> test_cond == (|ki_s))
        else $error("key input test condition wrong");

    timer_cond_a: assert property (
        op_operand[2:0] == FKP_TST_TIMER && !op_operand[FKP_TST_SPECIAL]
        |-> test_cond == timer_zero)
        else $error("timer test condition wrong");

    special_cond_a: assert property (
        op_operand[FKP_TST_SPECIAL] && s1_s |-> test_cond)
        else $error("special input did not satisfy test condition");

    and_carry_a: assert property (
        active_op && (op_code == FKP_OP_AND || op_code == FKP_OP_XOR)
        |=> carry_bit == ($past(acc_value[FKP_ACC_MSB]) & $past(op_operand[FKP_ACC_MSB])))
        else $error("logic operation carry wrong");

    rotate_carry_a: assert property (
        active_op && (op_code == FKP_OP_RL || op_code == FKP_OP_RLZ)
        |=> carry_bit == $past(acc_value[FKP_ACC_MSB]))
        else $error("rotate carry wrong");

    inc_carry_a: assert property (
        active_op && (op_code == FKP_OP_INC || op_code == FKP_OP_SET_CARRY_ADD_OP)
        |=> carry_bit == ($past(acc_value) == FKP_ACC_FULL))
        else $error("increment carry wrong");

    or_clear_a: assert property (
        active_op && op_code == FKP_OP_OR |=> !carry_bit)
        else $error("or did not clear carry");

    load_clear_a: assert property (
        active_op && (op_code == FKP_OP_MOV || op_code == FKP_OP_IN) |=> !carry_bit)
        else $error("accumulator load did not clear carry");

    scan_pd_a: assert property (
        scan_pd_en == ~scan_oe[0] && scan_oe == {8{scan_oe[0]}})
        else $error("key-scan pull-down and direction disagree");

    reset_scan_a: assert property (disable iff (1'b0)
        !nrst |=> scan_out == FKP_RST_SCAN && scan_oe == {8{1'b1}})
        else $error("key-scan port reset state wrong");

    s0_off_read_a: assert property (
        !st_q.mode_ctl[FKP_MODE_S0_IN] |-> keyin_read[2])
        else $error("special input zero not read as one in off mode");

    cover_test_c:    cover property (active_op && op_code == FKP_OP_TEST && test_cond);
    cover_standby_c: cover property (standby ##[1:20] !standby);
    cover_write_c:   cover property (s_axi_bvalid && s_axi_bready);
    cover_read_c:    cover property (s_axi_rvalid && s_axi_rready);

endmodule
